// file: hw/tpc_cfg_resolve.sv
// picks forced or negotiated settings for the pma datapath
// assumes negotiation results are stable while autonegotiation is enabled
`timescale 1ns/1ns
module tpc_cfg_resolve (
   input wire tpc_pkg::tpc_ctrl_type ctrl,
   input wire tpc_pkg::tpc_neg_type neg,
   input wire logic hi_amp_able,
   output tpc_pkg::tpc_eff_type eff
);
   import tpc_pkg::*;

   always_comb begin
      eff.master = neg.an_enable ? neg.an_master : ctrl.role_master;
      eff.phy_type = (!neg.an_enable && neg.forced_cfg) ? ctrl.phy_type
                                                        : neg.an_phy_type;
      eff.tx_output_en = !ctrl.tx_disable;
      // a forced high level is refused when the part cannot drive it
      eff.high_amp = neg.an_enable ? neg.an_high_amp
                                   : (ctrl.high_amp && hi_amp_able);
      eff.eee_en = ctrl.eee;
      eff.loopback_en = ctrl.loopback;
   end

endmodule : tpc_cfg_resolve

// file: hw/tpc_map.svh
// register map constants for the single-pair pma control/status bank
// assumes 16-bit management registers addressed by clause 45 register address
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH

`define TPC_ADDR_SP_CTRL 16'h0834
`define TPC_ADDR_LR_CTRL 16'h08f6
`define TPC_ADDR_LR_STAT 16'h08f7

`define TPC_SP_CTRL_RST 16'h8002
`define TPC_LR_CTRL_RST 16'h0000
`define TPC_LR_STAT_RST 16'h2800
`define TPC_SP_TYPE_RST 4'h2
`define TPC_BIT_RST 1'b0

`define TPC_SP_RSV_BIT 15
`define TPC_SP_ROLE_BIT 14
`define TPC_SP_TYPE_MSB 3
`define TPC_SP_TYPE_LSB 0

`define TPC_LR_TXDIS_BIT 14
`define TPC_LR_HIAMP_BIT 12
`define TPC_LR_RSV11_BIT 11
`define TPC_LR_EEE_BIT 10
`define TPC_LR_LB_BIT 0

`define TPC_ST_LB_ABLE_BIT 13
`define TPC_ST_HIAMP_ABLE_BIT 12
`define TPC_ST_PD_ABLE_BIT 11
`define TPC_ST_EEE_ABLE_BIT 10

`define TPC_TYPE_LONG_REACH 4'h2

`endif

// file: hw/tpc_pkg.sv
// types shared by the pma control/status bank
// assumes the constants header supplies offsets and reset values
package tpc_pkg;

   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } tpc_mgmt_req_type;

   typedef struct packed {
      logic role_master;
      logic [3:0] phy_type;
      logic tx_disable;
      logic high_amp;
      logic rsv11;
      logic eee;
      logic loopback;
   } tpc_ctrl_type;

   typedef struct packed {
      logic an_enable;
      logic forced_cfg;
      logic an_master;
      logic [3:0] an_phy_type;
      logic an_high_amp;
   } tpc_neg_type;

   typedef struct packed {
      logic master;
      logic [3:0] phy_type;
      logic tx_output_en;
      logic high_amp;
      logic eee_en;
      logic loopback_en;
   } tpc_eff_type;

   typedef struct packed {
      logic role_master;
      logic hi_amp_able;
      logic hi_amp_sel;
   } tpc_strap_type;

   typedef enum logic [1:0] {
      TPC_CAPTURE = 2'b01,
      TPC_RUN = 2'b10
   } tpc_strap_state_type;

endpackage : tpc_pkg

// file: hw/tpc_pma_regs.sv
// single-pair pma control/status bank with management access port
// assumes a management agent presents one decoded request per cycle
// Notes on behaviour
// - single-pair control resets 0x8002, role from strap
// - bit 14 forces master/slave when negotiation off
// - type field used only forced and negotiation off
// - transmit disable bit suppresses transmit output
// - bit 12 selects high amplitude when ability strap set, strap reset
// - amplitude bit ignored while negotiation enabled
// - bit 0 loops transmit back to receive
// - status resets 0x2800, every field read-only
// - status bit 13 always one: loopback able
// - status bit 12 reports high amplitude strap
// - status bit 11 one: power-down able
// - eee ability zero; eee enable resets zero
`timescale 1ns/1ns
`include "tpc_map.svh"
module tpc_pma_regs (
   input wire logic core_clk,
   input wire logic resetn,
   input wire tpc_pkg::tpc_mgmt_req_type mgmt_req,
   output logic mgmt_ack,
   output logic [15:0] mgmt_rdata,
   input wire tpc_pkg::tpc_strap_type strap_pins,
   input wire tpc_pkg::tpc_neg_type neg,
   output tpc_pkg::tpc_eff_type eff,
   output logic regs_ready
);
   import tpc_pkg::*;

   tpc_ctrl_type ctrl_r, ctrl_nxt;
   tpc_eff_type eff_r, eff_nxt;
   tpc_strap_type straps;
   logic strap_load;
   logic ready;
   logic ack_r, ack_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic take;

   function automatic logic [15:0] sp_word(input tpc_ctrl_type c);
      logic [15:0] w;
      w = 16'h0000;
      w[`TPC_SP_RSV_BIT] = 1'b1;
      w[`TPC_SP_ROLE_BIT] = c.role_master;
      w[`TPC_SP_TYPE_MSB:`TPC_SP_TYPE_LSB] = c.phy_type;
      return w;
   endfunction : sp_word

   function automatic logic [15:0] lr_word(input tpc_ctrl_type c);
      logic [15:0] w;
      w = `TPC_LR_CTRL_RST;
      w[`TPC_LR_TXDIS_BIT] = c.tx_disable;
      w[`TPC_LR_HIAMP_BIT] = c.high_amp;
      w[`TPC_LR_RSV11_BIT] = c.rsv11;
      w[`TPC_LR_EEE_BIT] = c.eee;
      w[`TPC_LR_LB_BIT] = c.loopback;
      return w;
   endfunction : lr_word

   function automatic logic [15:0] stat_word(input logic able);
      logic [15:0] w;
      w = `TPC_LR_STAT_RST;
      w[`TPC_ST_HIAMP_ABLE_BIT] = able;
      return w;
   endfunction : stat_word

   // unmapped addresses are answered but hold no state
   function automatic logic is_mapped(input logic [15:0] ad);
      return ad == `TPC_ADDR_SP_CTRL || ad == `TPC_ADDR_LR_CTRL || ad == `TPC_ADDR_LR_STAT;
   endfunction : is_mapped

   tpc_strap_capture u_strap (
      .core_clk(core_clk),
      .resetn(resetn),
      .strap_pins(strap_pins),
      .straps(straps),
      .strap_load(strap_load),
      .ready(ready)
   );

   tpc_cfg_resolve u_resolve (
      .ctrl(ctrl_r),
      .neg(neg),
      .hi_amp_able(straps.hi_amp_able),
      .eff(eff_nxt)
   );

   // requests before the straps settle are dropped without an ack
   assign take = mgmt_req.req && ready;

   always_comb begin
      ctrl_nxt = ctrl_r;
      if (strap_load) begin
         ctrl_nxt.role_master = straps.role_master;
         ctrl_nxt.high_amp = straps.hi_amp_sel;
      end else if (take && mgmt_req.we) begin
         unique case (mgmt_req.addr)
            `TPC_ADDR_SP_CTRL: begin
               ctrl_nxt.role_master = mgmt_req.wdata[`TPC_SP_ROLE_BIT];
               // any pattern is stored; only long-reach is meaningful
               ctrl_nxt.phy_type =
                  mgmt_req.wdata[`TPC_SP_TYPE_MSB:`TPC_SP_TYPE_LSB];
            end
            `TPC_ADDR_LR_CTRL: begin
               ctrl_nxt.tx_disable = mgmt_req.wdata[`TPC_LR_TXDIS_BIT];
               ctrl_nxt.high_amp = mgmt_req.wdata[`TPC_LR_HIAMP_BIT];
               ctrl_nxt.rsv11 = mgmt_req.wdata[`TPC_LR_RSV11_BIT];
               ctrl_nxt.eee = mgmt_req.wdata[`TPC_LR_EEE_BIT];
               ctrl_nxt.loopback = mgmt_req.wdata[`TPC_LR_LB_BIT];
            end
            default: begin
               // status and unmapped writes change nothing
               ctrl_nxt = ctrl_r;
            end
         endcase
      end
   end

   always_comb begin
      ack_nxt = take;
      rdata_nxt = rdata_r;
      if (take && !mgmt_req.we) begin
         unique case (mgmt_req.addr)
            `TPC_ADDR_SP_CTRL: rdata_nxt = sp_word(ctrl_r);
            `TPC_ADDR_LR_CTRL: rdata_nxt = lr_word(ctrl_r);
            `TPC_ADDR_LR_STAT: rdata_nxt = stat_word(straps.hi_amp_able);
            default: rdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r.role_master <= `TPC_BIT_RST;
         ctrl_r.phy_type <= `TPC_SP_TYPE_RST;
         ctrl_r.tx_disable <= `TPC_BIT_RST;
         ctrl_r.high_amp <= `TPC_BIT_RST;
         ctrl_r.rsv11 <= `TPC_BIT_RST;
         ctrl_r.eee <= `TPC_BIT_RST;
         ctrl_r.loopback <= `TPC_BIT_RST;
         eff_r <= '0;
         ack_r <= 1'b0;
         rdata_r <= 16'h0000;
      end else begin
         ctrl_r <= ctrl_nxt;
         eff_r <= eff_nxt;
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign mgmt_ack = ack_r;
   assign mgmt_rdata = rdata_r;
   assign eff = eff_r;
   assign regs_ready = ready;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   // read checks look one edge after the take: ack and read data are registered
   sequence rd_at(logic [15:0] a);
      take && !mgmt_req.we && mgmt_req.addr == a;
   endsequence

   sequence wr_at(logic [15:0] a);
      take && mgmt_req.we && mgmt_req.addr == a;
   endsequence

   AST_SP_RESET: assert property ($rose(ready) |->
         ctrl_r.phy_type == `TPC_SP_TYPE_RST && !ctrl_r.tx_disable && !ctrl_r.loopback &&
         ctrl_r.role_master == straps.role_master)
      else $error("single-pair control not at reset value");

   AST_STRAP_ROLE: assert property (strap_load |=>
         ctrl_r.role_master == $past(straps.role_master))
      else $error("reset role not taken from strap");

   AST_SP_RSV_ONE: assert property (rd_at(`TPC_ADDR_SP_CTRL) |=>
         mgmt_ack && mgmt_rdata[`TPC_SP_RSV_BIT] && mgmt_rdata[13:4] == 10'h000)
      else $error("single-pair reserved bits read wrong");

   AST_SP_READBACK: assert property (rd_at(`TPC_ADDR_SP_CTRL) |=>
         mgmt_rdata[`TPC_SP_ROLE_BIT] == $past(ctrl_r.role_master) &&
         mgmt_rdata[`TPC_SP_TYPE_MSB:`TPC_SP_TYPE_LSB] == $past(ctrl_r.phy_type))
      else $error("single-pair fields read back wrong");

   AST_ROLE_STORE: assert property (wr_at(`TPC_ADDR_SP_CTRL) |=>
         ctrl_r.role_master == $past(mgmt_req.wdata[`TPC_SP_ROLE_BIT]))
      else $error("role write not stored");

   AST_TYPE_STORE: assert property (wr_at(`TPC_ADDR_SP_CTRL) |=>
         ctrl_r.phy_type == $past(mgmt_req.wdata[`TPC_SP_TYPE_MSB:`TPC_SP_TYPE_LSB]))
      else $error("type write not stored");

   AST_SP_WRITE_KEEP: assert property (wr_at(`TPC_ADDR_SP_CTRL) |=>
         $stable({ctrl_r.tx_disable, ctrl_r.high_amp, ctrl_r.rsv11}) &&
         $stable({ctrl_r.eee, ctrl_r.loopback}))
      else $error("single-pair write disturbed long-reach control");

   AST_LR_WRITE_KEEP: assert property (wr_at(`TPC_ADDR_LR_CTRL) |=>
         $stable({ctrl_r.role_master, ctrl_r.phy_type}))
      else $error("long-reach write disturbed single-pair control");

   AST_ROLE: assert property (ready && !neg.an_enable |=>
         eff.master == $past(ctrl_r.role_master))
      else $error("forced role not applied");

   AST_ROLE_NEG: assert property (neg.an_enable |=>
         eff.master == $past(neg.an_master))
      else $error("negotiated role not applied");

   AST_TYPE: assert property (!neg.an_enable && neg.forced_cfg |=>
         eff.phy_type == $past(ctrl_r.phy_type))
      else $error("forced type not applied");

   AST_TYPE_NEG: assert property (neg.an_enable || !neg.forced_cfg |=>
         eff.phy_type == $past(neg.an_phy_type))
      else $error("type not taken from negotiation");

   AST_TXDIS: assert property (wr_at(`TPC_ADDR_LR_CTRL) |->
         ##2 eff.tx_output_en == !$past(mgmt_req.wdata[`TPC_LR_TXDIS_BIT], 2))
      else $error("transmit disable did not reach output");

   AST_EFF_DIRECT: assert property (1'b1 |=>
         eff.tx_output_en == !$past(ctrl_r.tx_disable) && eff.eee_en == $past(ctrl_r.eee) &&
         eff.loopback_en == $past(ctrl_r.loopback))
      else $error("direct control bits not passed to pma");

   AST_HIAMP: assert property (!neg.an_enable |=>
         eff.high_amp == $past(ctrl_r.high_amp && straps.hi_amp_able))
      else $error("forced amplitude wrong");

   AST_HIAMP_REFUSED: assert property (!neg.an_enable && !straps.hi_amp_able |=>
         !eff.high_amp)
      else $error("high amplitude forced without ability");

   AST_STRAP_AMP: assert property (strap_load |=>
         ctrl_r.high_amp == $past(straps.hi_amp_sel))
      else $error("reset amplitude select not taken from strap");

   AST_HIAMP_NEG: assert property (neg.an_enable |=>
         eff.high_amp == $past(neg.an_high_amp))
      else $error("amplitude did not follow negotiation");

   AST_LOOPBACK: assert property (wr_at(`TPC_ADDR_LR_CTRL) |->
         ##2 eff.loopback_en == $past(mgmt_req.wdata[`TPC_LR_LB_BIT], 2))
      else $error("loopback enable not applied");

   AST_STAT: assert property (rd_at(`TPC_ADDR_LR_STAT) |=>
         (mgmt_rdata & ~16'h1000) == `TPC_LR_STAT_RST)
      else $error("status fixed bits wrong");

   AST_STAT_LB: assert property (rd_at(`TPC_ADDR_LR_STAT) |=>
         mgmt_rdata[`TPC_ST_LB_ABLE_BIT])
      else $error("loopback ability not reported");

   AST_STAT_ABLE: assert property (rd_at(`TPC_ADDR_LR_STAT) |=>
         mgmt_rdata[`TPC_ST_HIAMP_ABLE_BIT] == $past(straps.hi_amp_able))
      else $error("high amplitude ability wrong");

   AST_STAT_PD: assert property (rd_at(`TPC_ADDR_LR_STAT) |=>
         mgmt_rdata[`TPC_ST_PD_ABLE_BIT] && !mgmt_rdata[`TPC_ST_EEE_ABLE_BIT])
      else $error("power-down or eee ability wrong");

   AST_EEE: assert property (wr_at(`TPC_ADDR_LR_CTRL) |=>
         ctrl_r.eee == $past(mgmt_req.wdata[`TPC_LR_EEE_BIT]))
      else $error("eee enable not stored");

   AST_LR_READBACK: assert property (rd_at(`TPC_ADDR_LR_CTRL) |=>
         mgmt_rdata[`TPC_LR_TXDIS_BIT] == $past(ctrl_r.tx_disable) &&
         mgmt_rdata[`TPC_LR_HIAMP_BIT] == $past(ctrl_r.high_amp) &&
         mgmt_rdata[`TPC_LR_EEE_BIT] == $past(ctrl_r.eee) &&
         mgmt_rdata[`TPC_LR_LB_BIT] == $past(ctrl_r.loopback))
      else $error("long-reach fields read back wrong");

   AST_LR_RSV_READ: assert property (rd_at(`TPC_ADDR_LR_CTRL) |=>
         !mgmt_rdata[15] && !mgmt_rdata[13] && mgmt_rdata[9:1] == 9'h000)
      else $error("long-reach reserved bits read wrong");

   AST_RO_WRITE: assert property (take && mgmt_req.we && !strap_load &&
         mgmt_req.addr == `TPC_ADDR_LR_STAT |=> $stable(ctrl_r))
      else $error("status write changed control state");

   AST_UNMAPPED_WRITE: assert property (take && mgmt_req.we &&
         !is_mapped(mgmt_req.addr) |=> $stable(ctrl_r))
      else $error("unmapped write changed control state");

   AST_UNMAPPED_READ: assert property (take && !mgmt_req.we &&
         !is_mapped(mgmt_req.addr) |=> mgmt_rdata == 16'h0000)
      else $error("unmapped read not zero");

   AST_ACK_PULSE: assert property (1'b1 |=>
         mgmt_ack == $past(take))
      else $error("ack not one cycle after take");

   AST_RDATA_HOLD: assert property (!(take && !mgmt_req.we) |=>
         $stable(mgmt_rdata))
      else $error("read data changed without a read");

   AST_ACK: assert property (mgmt_req.req && !ready |=> !mgmt_ack)
      else $error("ack given before ready");

   COV_STAT_READ: cover property (rd_at(`TPC_ADDR_LR_STAT) ##1 mgmt_ack);
   COV_FORCED_MASTER: cover property (!neg.an_enable && ctrl_r.role_master ##1 eff.master);
   COV_LOOPBACK: cover property (eff.loopback_en && !eff.tx_output_en);
   COV_NEG_HIAMP: cover property (neg.an_enable && neg.an_high_amp ##1 eff.high_amp);
   COV_EARLY_REQ: cover property (mgmt_req.req && !ready);

endmodule : tpc_pma_regs

// file: hw/tpc_strap_capture.sv
// catches the strap pins once after reset release and signals the load
// assumes strap pins are steady around reset release
`timescale 1ns/1ns
module tpc_strap_capture (
   input wire logic core_clk,
   input wire logic resetn,
   input wire tpc_pkg::tpc_strap_type strap_pins,
   output tpc_pkg::tpc_strap_type straps,
   output logic strap_load,
   output logic ready
);
   import tpc_pkg::*;

   tpc_strap_state_type state_r, state_nxt;
   tpc_strap_type straps_r, straps_nxt;
   logic load_r, load_nxt;

   // pins are sampled by a clocked process, never by the reset itself
   always_comb begin
      state_nxt = state_r;
      straps_nxt = straps_r;
      load_nxt = 1'b0;
      unique case (state_r)
         TPC_CAPTURE: begin
            straps_nxt = strap_pins;
            load_nxt = 1'b1;
            state_nxt = TPC_RUN;
         end
         TPC_RUN: begin
         end
         default: state_nxt = TPC_CAPTURE;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= TPC_CAPTURE;
         straps_r <= '0;
         load_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         straps_r <= straps_nxt;
         load_r <= load_nxt;
      end
   end

   assign straps = straps_r;
   assign strap_load = load_r;
   assign ready = (state_r == TPC_RUN) && !load_r;

endmodule : tpc_strap_capture

// file: testbench/tpc_pma_regs_tb_top.sv
// self-checking bench for the pma control/status bank
// assumes the design files and the map header are compiled first
`timescale 1ns/1ns
`include "tpc_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("Error at %0t ns: got %h expected %h", $time, (g), (e)); end end
module tpc_pma_regs_tb_top;
   import tpc_pkg::*;
   logic core_clk;
   logic resetn;
   tpc_mgmt_req_type mgmt_req;
   logic mgmt_ack;
   logic [15:0] mgmt_rdata;
   tpc_strap_type strap_pins;
   tpc_neg_type neg;
   tpc_eff_type eff;
   logic regs_ready;
   int n_errors;
   int checked;
   logic [31:0] seed;
   logic [15:0] m_sp;
   logic [15:0] m_lr;
   logic m_able;
   logic [15:0] rd;
   logic [31:0] r;
   logic [15:0] a;
   logic [15:0] wd;
   logic [15:0] addrs [4];

   tpc_pma_regs u_dut (
      .core_clk(core_clk),
      .resetn(resetn),
      .mgmt_req(mgmt_req),
      .mgmt_ack(mgmt_ack),
      .mgmt_rdata(mgmt_rdata),
      .strap_pins(strap_pins),
      .neg(neg),
      .eff(eff),
      .regs_ready(regs_ready)
   );

   always #10 core_clk = ~core_clk;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   // status word is fixed apart from the amplitude ability strap
   function automatic logic [15:0] exp_rd(input logic [15:0] ad);
      case (ad)
         `TPC_ADDR_SP_CTRL: return m_sp;
         `TPC_ADDR_LR_CTRL: return m_lr;
         `TPC_ADDR_LR_STAT: return {3'b001, m_able, 12'h800};
         default: return 16'h0000;
      endcase
   endfunction : exp_rd

   task wrap_up;
      if (n_errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   task chk_eff;
      tpc_eff_type e;
      e.master = neg.an_enable ? neg.an_master : m_sp[14];
      e.phy_type = (!neg.an_enable && neg.forced_cfg) ? m_sp[3:0] : neg.an_phy_type;
      e.tx_output_en = !m_lr[14];
      e.high_amp = neg.an_enable ? neg.an_high_amp : (m_lr[12] & m_able);
      e.eee_en = m_lr[10];
      e.loopback_en = m_lr[0];
      `CHK(eff, e)
   endtask : chk_eff

   // one request; the registered ack stands in the cycle right after the take
   task xfer(input logic we, input logic [15:0] ad, input logic [15:0] wdat);
      mgmt_req = '{1'b1, we, ad, wdat};
      @(negedge core_clk);
      `CHK(mgmt_ack, 1'b1)
      rd = mgmt_rdata;
      mgmt_req.req = 1'b0;
      if (we && ad == `TPC_ADDR_SP_CTRL) begin
         m_sp = 16'h8000 | (wdat & 16'h400f);
      end
      if (we && ad == `TPC_ADDR_LR_CTRL) begin
         m_lr = wdat & 16'h5c01;
      end
      @(negedge core_clk);
      `CHK(mgmt_ack, 1'b0)
      if (!we) begin
         `CHK(rd, exp_rd(ad))
      end
   endtask : xfer

   task do_reset(input tpc_strap_type s);
      int i;
      resetn = 1'b0;
      strap_pins = s;
      mgmt_req = '0;
      repeat (3) @(negedge core_clk);
      `CHK(mgmt_ack, 1'b0)
      `CHK(regs_ready, 1'b0)
      m_able = s.hi_amp_able;
      m_sp = 16'h8002 | {1'b0, s.role_master, 14'h0000};
      m_lr = {3'b000, s.hi_amp_sel, 12'h000};
      resetn = 1'b1;
      // write attempted before straps load must be dropped
      mgmt_req = '{1'b1, 1'b1, `TPC_ADDR_SP_CTRL, 16'h0000};
      @(negedge core_clk);
      mgmt_req.req = 1'b0;
      for (i = 0; i < 8 && regs_ready !== 1'b1; i++) @(negedge core_clk);
      if (regs_ready !== 1'b1) begin
         n_errors++;
         wrap_up();
      end
      `CHK(mgmt_ack, 1'b0)
      @(negedge core_clk);
      `CHK(mgmt_ack, 1'b0)
      for (i = 0; i < 4; i++) xfer(1'b0, addrs[i], 16'h0000);
      chk_eff();
   endtask : do_reset

   task rand_run(input int n);
      int i;
      for (i = 0; i < n; i++) begin
         r = xs();
         neg = tpc_neg_type'(r[7:0]);
         a = addrs[r[9:8]];
         wd = r[31:16];
         if (a == `TPC_ADDR_SP_CTRL) wd[3:0] = `TPC_TYPE_LONG_REACH;
         xfer(r[10], a, wd);
         chk_eff();
      end
   endtask : rand_run

   initial begin
      core_clk = 1'b0;
      resetn = 1'b0;
      mgmt_req = '0;
      neg = '0;
      strap_pins = '0;
      seed = 32'd18926;
      n_errors = 0;
      checked = 0;
      addrs = '{`TPC_ADDR_SP_CTRL, `TPC_ADDR_LR_CTRL, `TPC_ADDR_LR_STAT, 16'h08f8};
      do_reset('{1'b1, 1'b1, 1'b1});
      neg = '{1'b0, 1'b1, 1'b0, 4'h3, 1'b0};
      // the 0xfff2 and all-ones writes hit the reserved bits; the status write is all zeros
      xfer(1'b1, `TPC_ADDR_SP_CTRL, 16'hfff2);
      xfer(1'b1, `TPC_ADDR_LR_CTRL, 16'hffff);
      xfer(1'b1, `TPC_ADDR_LR_STAT, 16'h0000);
      xfer(1'b1, 16'h08f8, 16'hffff);
      for (int i = 0; i < 4; i++) xfer(1'b0, addrs[i], 16'h0000);
      chk_eff();
      xfer(1'b1, `TPC_ADDR_SP_CTRL, 16'h0002);
      xfer(1'b1, `TPC_ADDR_LR_CTRL, 16'h1000);
      xfer(1'b0, `TPC_ADDR_SP_CTRL, 16'h0000);
      chk_eff();
      neg.an_enable = 1'b1;
      neg.an_master = 1'b1;
      neg.an_high_amp = 1'b0;
      @(negedge core_clk);
      @(negedge core_clk);
      chk_eff();
      rand_run(60);
      // second reset mid-run with role and ability straps cleared, amplitude select still set
      do_reset('{1'b0, 1'b0, 1'b1});
      rand_run(40);
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      wrap_up();
   end

endmodule : tpc_pma_regs_tb_top
